// File: adc_cal_defs.vh
/*
 * Shared constants of the ADC calibration sequencer: bit positions of the
 * calibration control register, reset values, channel codes, averaging
 * counts and the timing figures of a calibration cycle.
 * Assumes it is included by its bare name; definitions only.
 */
`ifndef ADC_CAL_DEFS_VH
`define ADC_CAL_DEFS_VH

// Bit positions of the calibration control register.
`define CAL_START_BIT      0
`define CAL_TYPE_BIT       1
`define CAL_MODE_BIT       2
`define CAL_OFS_DIS_BIT    3
`define CAL_AVG_LO_BIT     4
`define CAL_AVG_HI_BIT     5
`define CAL_GAIN_DIS_BIT   6
`define CAL_BUSY_BIT       7
`define CAL_CTRL_RESET     8'h00
`define CAL_CTRL_BITS_RESET 7'h00

// Control values that start offset and gain cycles with 31 averages.
`define CAL_CMD_OFFSET     8'h25
`define CAL_CMD_GAIN       8'h27

// Channel codes of the internal ground and internal reference.
`define CAL_CH_INT_GND     4'hb
`define CAL_CH_INT_REF     4'hc

// Readings averaged per bit decision for each average select code.
`define CAL_AVG_N0         6'h07
`define CAL_AVG_N1         6'h0f
`define CAL_AVG_N2         6'h1f
`define CAL_AVG_N3         6'h3f

// Reciprocals of the averaging counts, scaled by 2^16.
`define CAL_RECIP_N0       14'h2492
`define CAL_RECIP_N1       14'h1111
`define CAL_RECIP_N2       14'h0842
`define CAL_RECIP_N3       14'h0410
`define CAL_RECIP_SHIFT    16

// Cycle shape: bit decisions per cycle and converter clocks per reading, acquisition excluded.
`define CAL_BIT_DECISIONS  4'he
`define CAL_READ_BASE      5'h10

// Result range and reset values of the coefficients.
`define CAL_FULL_SCALE     12'hfff
`define CAL_OFS_RESET      12'h000
`define CAL_GAIN_RESET     12'hfff
`define CAL_GAIN_SHIFT     12

`endif

// File: cal_clock_divider.v
/*
 * Converter clock tick generator: one core cycle wide tick every
 * divRatio core cycles.
 * Assumes divRatio comes from logic on ref_clk; a ratio of zero acts as one.
 */
`timescale 1ns/1ps

module cal_clock_divider (
   input  wire       ref_clk,   // Core clock, 200 MHz.
   input  wire       rst,       // Asynchronous reset, active high.
   input  wire [5:0] divRatio,  // Core cycles per converter clock.
   output reg        convTick   // One-cycle converter clock tick.
);

   reg [5:0] divCnt_r;
   reg [5:0] divCnt_nxt;
   wire      wrapNow;

   // A ratio of zero is treated as one so the tick never stops.
   assign wrapNow = (divCnt_r >= divRatio) || (divCnt_r == 6'h3f) ||
                    (divRatio == 6'h00) ||
                    (divCnt_r == divRatio - 6'h01);

   always @* begin
      divCnt_nxt = wrapNow ? 6'h00 : divCnt_r + 6'h01;
   end

   // Counter and tick register.
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         divCnt_r <= 6'h00;
         convTick <= 1'b0;
      end else begin
         divCnt_r <= divCnt_nxt;
         convTick <= wrapNow;
      end
   end

endmodule // cal_clock_divider

// File: adc_calibration_sequencer.v
/*
 * ADC calibration sequencer: holds the calibration control register, times
 * offset and gain calibration cycles, averages converter readings, stores
 * the coefficients and applies them to later conversion results.
 * Assumes the converter, channel selector and configuration live on
 * ref_clk; rawSample is valid at the last converter tick of each reading.
 */
`timescale 1ns/1ps
`include "adc_cal_defs.vh"

module adc_calibration_sequencer (
   input  wire        ref_clk,      // Core clock, 200 MHz.
   input  wire        rst,          // Asynchronous reset, active high.
   input  wire        ctrlWrEn,     // Write strobe of the control register.
   input  wire [7:0]  ctrlWrData,   // Value written to the control register.
   input  wire [3:0]  channelSelect,// Channel selector code.
   input  wire [5:0]  divRatio,     // Core cycles per converter clock.
   input  wire [1:0]  acqSel,       // Acquisition clocks minus one.
   input  wire [11:0] rawSample,    // Converter reading during calibration.
   input  wire [11:0] convResult,   // Raw result of a normal conversion.
   input  wire        convValid,    // Pulse: convResult is valid.
   output reg  [7:0]  ctrlRdData_r, // Read value of the control register.
   output reg  [3:0]  calChannel_r, // Channel held for the running cycle.
   output reg         acqWindow_r,  // High while a reading acquires.
   output reg         sampleTake_r, // Pulse: reading taken this cycle.
   output reg         calDone_r,    // Pulse: calibration cycle ended.
   output reg  [11:0] offsetCoeff_r,// Stored offset coefficient.
   output reg  [11:0] gainCoeff_r,  // Stored full-scale reading.
   output reg  [11:0] corrResult_r, // Corrected conversion result.
   output reg         corrValid_r   // Pulse: corrResult_r is valid.
);

   ////////////////////////////////////////////////////////////////////////
   // States and decoding functions.

   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_READ  = 3'b010;
   localparam [2:0] ST_STORE = 3'b100;

   // Readings per bit decision for an average select code.
   function [5:0] avgCount;
      input [1:0] code;
      begin
         case (code)
            2'b00:   avgCount = `CAL_AVG_N0;
            2'b01:   avgCount = `CAL_AVG_N1;
            2'b10:   avgCount = `CAL_AVG_N2;
            default: avgCount = `CAL_AVG_N3;
         endcase
      end
   endfunction

   // Scaled reciprocal of the same count, used to form the mean.
   function [13:0] avgRecip;
      input [1:0] code;
      begin
         case (code)
            2'b00:   avgRecip = `CAL_RECIP_N0;
            2'b01:   avgRecip = `CAL_RECIP_N1;
            2'b10:   avgRecip = `CAL_RECIP_N2;
            default: avgRecip = `CAL_RECIP_N3;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Converter clock ticks.

   wire convTick;
   cal_clock_divider u_div (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .divRatio (divRatio),
      .convTick (convTick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Control register and sequencer state.

   reg  [2:0]  state_r;
   reg  [2:0]  state_nxt;
   reg  [6:0]  ctrl_r;          // Bits 6..0; busy is separate.
   reg  [6:0]  ctrl_nxt;
   reg         busy_r;
   reg         busy_nxt;
   reg         type_r;          // Latched type of the running cycle.
   reg         type_nxt;
   reg  [1:0]  avgSel_r;
   reg  [1:0]  avgSel_nxt;
   reg  [4:0]  tickCnt_r;
   reg  [4:0]  tickCnt_nxt;
   reg  [5:0]  avgCnt_r;
   reg  [5:0]  avgCnt_nxt;
   reg  [3:0]  bitCnt_r;
   reg  [3:0]  bitCnt_nxt;
   reg  [17:0] sum_r;
   reg  [17:0] sum_nxt;
   reg  [3:0]  channel_nxt;
   reg  [11:0] offset_nxt;
   reg  [11:0] gain_nxt;
   reg         done_nxt;
   reg         take_nxt;

   wire [4:0]  readLen;
   wire [4:0]  acqLen;
   wire        readEnd;
   wire        startReq;
   wire [31:0] meanProd;
   wire [11:0] meanVal;

   // One reading spans 16 plus the acquisition converter clocks.
   assign acqLen   = {3'b000, acqSel} + 5'h01;
   assign readLen  = `CAL_READ_BASE + acqLen;
   assign readEnd  = convTick && (tickCnt_r == readLen - 5'h01);
   // A start needs the start bit and the calibration mode bit together.
   assign startReq = ctrlWrEn && ctrlWrData[`CAL_START_BIT] &&
                     ctrlWrData[`CAL_MODE_BIT];
   // Mean of the last bit decision's readings.
   assign meanProd = {14'h0000, sum_r} * {18'h00000, avgRecip(avgSel_r)};
   assign meanVal  = meanProd[`CAL_RECIP_SHIFT +: 12];

   // Next-state logic of the sequencer and the control register.
   always @* begin
      state_nxt   = state_r;
      ctrl_nxt    = ctrl_r;
      busy_nxt    = busy_r;
      type_nxt    = type_r;
      avgSel_nxt  = avgSel_r;
      tickCnt_nxt = tickCnt_r;
      avgCnt_nxt  = avgCnt_r;
      bitCnt_nxt  = bitCnt_r;
      sum_nxt     = sum_r;
      channel_nxt = calChannel_r;
      offset_nxt  = offsetCoeff_r;
      gain_nxt    = gainCoeff_r;
      done_nxt    = 1'b0;
      take_nxt    = 1'b0;
      // While a cycle runs only the disable bits take a write.
      if (ctrlWrEn && (state_r != ST_IDLE)) begin
         ctrl_nxt[`CAL_GAIN_DIS_BIT] = ctrlWrData[`CAL_GAIN_DIS_BIT];
         ctrl_nxt[`CAL_OFS_DIS_BIT]  = ctrlWrData[`CAL_OFS_DIS_BIT];
      end
      case (state_r)
         ST_IDLE: begin
            if (ctrlWrEn) begin
               ctrl_nxt = ctrlWrData[6:0];
               ctrl_nxt[`CAL_START_BIT] = startReq;
            end
            if (startReq) begin
               state_nxt   = ST_READ;
               busy_nxt    = 1'b1;
               type_nxt    = ctrlWrData[`CAL_TYPE_BIT];
               avgSel_nxt  = ctrlWrData[`CAL_AVG_HI_BIT:`CAL_AVG_LO_BIT];
               // The channel selector code is latched as given, whatever it carries.
               channel_nxt = channelSelect;
               tickCnt_nxt = 5'h00;
               avgCnt_nxt  = 6'h00;
               bitCnt_nxt  = 4'h0;
               sum_nxt     = 18'h00000;
            end
         end
         ST_READ: begin
            if (convTick)
               tickCnt_nxt = tickCnt_r + 5'h01;
            if (readEnd) begin
               tickCnt_nxt = 5'h00;
               take_nxt    = 1'b1;
               sum_nxt     = sum_r + {6'h00, rawSample};
               if (avgCnt_r == avgCount(avgSel_r) - 6'h01) begin
                  avgCnt_nxt = 6'h00;
                  if (bitCnt_r == `CAL_BIT_DECISIONS - 4'h1) begin
                     state_nxt = ST_STORE;
                  end else begin
                     bitCnt_nxt = bitCnt_r + 4'h1;
                     sum_nxt    = 18'h00000;
                  end
               end else begin
                  avgCnt_nxt = avgCnt_r + 6'h01;
               end
            end
         end
         ST_STORE: begin
            if (type_r)
               gain_nxt = meanVal;
            else
               offset_nxt = meanVal;
            ctrl_nxt[`CAL_START_BIT] = 1'b0;
            busy_nxt  = 1'b0;
            done_nxt  = 1'b1;
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
            busy_nxt  = 1'b0;
         end
      endcase
   end

   // Sequencer registers; every output is a flip-flop.
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r       <= ST_IDLE;
         ctrl_r        <= `CAL_CTRL_BITS_RESET;
         busy_r        <= 1'b0;
         type_r        <= 1'b0;
         avgSel_r      <= 2'b00;
         tickCnt_r     <= 5'h00;
         avgCnt_r      <= 6'h00;
         bitCnt_r      <= 4'h0;
         sum_r         <= 18'h00000;
         calChannel_r  <= 4'h0;
         offsetCoeff_r <= `CAL_OFS_RESET;
         gainCoeff_r   <= `CAL_GAIN_RESET;
         calDone_r     <= 1'b0;
         sampleTake_r  <= 1'b0;
         acqWindow_r   <= 1'b0;
         ctrlRdData_r  <= `CAL_CTRL_RESET;
      end else begin
         state_r       <= state_nxt;
         ctrl_r        <= ctrl_nxt;
         busy_r        <= busy_nxt;
         type_r        <= type_nxt;
         avgSel_r      <= avgSel_nxt;
         tickCnt_r     <= tickCnt_nxt;
         avgCnt_r      <= avgCnt_nxt;
         bitCnt_r      <= bitCnt_nxt;
         sum_r         <= sum_nxt;
         calChannel_r  <= channel_nxt;
         offsetCoeff_r <= offset_nxt;
         gainCoeff_r   <= gain_nxt;
         calDone_r     <= done_nxt;
         sampleTake_r  <= take_nxt;
         acqWindow_r   <= (state_nxt == ST_READ) && (tickCnt_nxt < acqLen);
         ctrlRdData_r  <= {busy_nxt, ctrl_nxt};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Coefficient correction of conversion results.

   reg  [11:0] ofsFixed;
   reg  [11:0] gainFixed;
   reg  signed [13:0] gainErr;
   reg  signed [26:0] gainProd;
   reg  signed [14:0] scaled;

   // Offset is removed first, then the gain error is scaled out. The
   // linear gain term avoids a divider at the price of a small error
   // near the edges of the correctable range.
   always @* begin
      ofsFixed  = convResult;
      if (!ctrl_r[`CAL_OFS_DIS_BIT])
         ofsFixed = (convResult > offsetCoeff_r) ?
                    convResult - offsetCoeff_r : 12'h000;
      gainErr  = $signed({2'b00, gainCoeff_r}) -
                 $signed({2'b00, `CAL_FULL_SCALE});
      gainProd = $signed({1'b0, ofsFixed}) * gainErr;
      scaled   = $signed({3'b000, ofsFixed}) -
                 $signed(gainProd[26:`CAL_GAIN_SHIFT]);
      if (ctrl_r[`CAL_GAIN_DIS_BIT])
         gainFixed = ofsFixed;
      else if (scaled < 15'sh0000)
         gainFixed = 12'h000;
      else if (scaled > $signed({3'b000, `CAL_FULL_SCALE}))
         gainFixed = `CAL_FULL_SCALE;
      else
         gainFixed = scaled[11:0];
   end

   // Corrected result register, one cycle behind convValid.
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         corrResult_r <= 12'h000;
         corrValid_r  <= 1'b0;
      end else begin
         corrValid_r <= convValid;
         if (convValid)
            corrResult_r <= gainFixed;
      end
   end

endmodule // adc_calibration_sequencer

// File: adc_cal_seq_chk.sv
/*
 * Port checker of the ADC calibration sequencer: start, busy framing,
 * cycle length, coefficient updates and correction timing.
 * Assumes it is bound to adc_calibration_sequencer on one clock, ref_clk.
 */
`timescale 1ns/1ps

module adc_cal_seq_chk (
   input wire        ref_clk,       // Core clock.
   input wire        rst,           // Asynchronous reset, active high.
   input wire        ctrlWrEn,      // Control write strobe.
   input wire [7:0]  ctrlWrData,    // Control write value.
   input wire [3:0]  channelSelect, // Channel selector code.
   input wire [5:0]  divRatio,      // Core cycles per converter clock.
   input wire [1:0]  acqSel,        // Acquisition clocks minus one.
   input wire [11:0] rawSample,     // Calibration reading.
   input wire [11:0] convResult,    // Normal conversion result.
   input wire        convValid,     // Conversion result valid.
   input wire [7:0]  ctrlRdData_r,  // Control register read value.
   input wire [3:0]  calChannel_r,  // Latched channel.
   input wire        acqWindow_r,   // Acquisition window.
   input wire        sampleTake_r,  // Reading taken.
   input wire        calDone_r,     // Cycle end pulse.
   input wire [11:0] offsetCoeff_r, // Offset coefficient.
   input wire [11:0] gainCoeff_r,   // Gain coefficient.
   input wire [11:0] corrResult_r,  // Corrected result.
   input wire        corrValid_r    // Corrected result valid.
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////
   // Busy length counter; it holds the count until the cycle after busy
   // falls, so the cycle end pulse can be judged against the formula.
   wire        busy = ctrlRdData_r[7];
   wire        idleStart = ctrlWrEn && !busy && ctrlWrData[0] && ctrlWrData[2];
   wire [31:0] avgN = ctrlRdData_r[5] ? (ctrlRdData_r[4] ? 63 : 31)
                                      : (ctrlRdData_r[4] ? 15 : 7);
   wire [31:0] tCal = 14 * avgN * (17 + acqSel) *
                      ((divRatio == 6'h00) ? 1 : divRatio);
   reg  [31:0] busyCnt_r;

   // Counts core cycles with busy high.
   always @(posedge ref_clk or posedge rst) begin
      if (rst)
         busyCnt_r <= 0;
      else if (busy)
         busyCnt_r <= busyCnt_r + 1;
      else
         busyCnt_r <= 0;
   end

   ////////////////////////////////////////////////////////////////////////
   property p_start;
      idleStart |=> busy && ctrlRdData_r[0] &&
                    calChannel_r == $past(channelSelect);
   endproperty
   a_start: assert property (p_start) else $error("start not taken");
   property p_noMode;
      ctrlWrEn && !busy && !ctrlWrData[2] |=> !busy && !ctrlRdData_r[0] &&
         ctrlRdData_r[6:1] == $past(ctrlWrData[6:1]);
   endproperty
   a_noMode: assert property (p_noMode) else $error("bad idle write");
   property p_done;
      calDone_r |-> !busy && !ctrlRdData_r[0] && $past(busy);
   endproperty
   a_done: assert property (p_done) else $error("bad cycle end");
   property p_fall;
      $fell(busy) |-> calDone_r;
   endproperty
   a_fall: assert property (p_fall) else $error("busy fell early");
   property p_len;
      calDone_r |-> busyCnt_r >= tCal && busyCnt_r <= tCal + 3;
   endproperty
   a_len: assert property (p_len) else $error("bad cycle length");
   property p_chan;
      busy && $past(busy) |-> $stable(calChannel_r);
   endproperty
   a_chan: assert property (p_chan) else $error("channel moved");
   property p_ofs;
      !$stable(offsetCoeff_r) |-> calDone_r && !ctrlRdData_r[1];
   endproperty
   a_ofs: assert property (p_ofs) else $error("stray offset update");
   property p_gain;
      !$stable(gainCoeff_r) |-> calDone_r && ctrlRdData_r[1];
   endproperty
   a_gain: assert property (p_gain) else $error("stray gain update");
   property p_corr;
      convValid |=> corrValid_r;
   endproperty
   a_corr: assert property (p_corr) else $error("no corrected result");
   property p_busyWr;
      busy && ctrlWrEn |=> ctrlRdData_r[5:4] == $past(ctrlRdData_r[5:4]) &&
         ctrlRdData_r[2:1] == $past(ctrlRdData_r[2:1]) &&
         ctrlRdData_r[6] == $past(ctrlWrData[6]) &&
         ctrlRdData_r[3] == $past(ctrlWrData[3]);
   endproperty
   a_busyWr: assert property (p_busyWr) else $error("bad busy write");
   property p_acq;
      $rose(acqWindow_r) |-> busy && (sampleTake_r || $past(idleStart));
   endproperty
   a_acq: assert property (p_acq) else $error("stray acquisition");

   // Main scenarios.
   c_ofs: cover property (calDone_r && !ctrlRdData_r[1]);
   c_gain: cover property (calDone_r && ctrlRdData_r[1]);
   c_busyWr: cover property (busy && ctrlWrEn);
   c_corr: cover property (corrValid_r);
endmodule // adc_cal_seq_chk

bind adc_calibration_sequencer adc_cal_seq_chk u_chk (.ref_clk, .rst,
   .ctrlWrEn, .ctrlWrData, .channelSelect, .divRatio, .acqSel, .rawSample,
   .convResult, .convValid, .ctrlRdData_r, .calChannel_r, .acqWindow_r,
   .sampleTake_r, .calDone_r, .offsetCoeff_r, .gainCoeff_r, .corrResult_r,
   .corrValid_r);

// File: tb_top.sv
/*
 * Self-checking bench of the ADC calibration sequencer: table of
 * calibration cycles, then idle, busy-write, correction and reset cases.
 * Assumes adc_calibration_sequencer and adc_cal_defs.vh are compiled.
 */
`timescale 1ns/1ps
`include "adc_cal_defs.vh"

module tb_top;
   logic ref_clk, rst, ctrlWrEn, convValid;
   logic [7:0] ctrlWrData;
   logic [3:0] channelSelect;
   logic [5:0] divRatio;
   logic [1:0] acqSel;
   logic [11:0] rawSample, convResult;
   wire [7:0] ctrlRdData_r;
   wire [3:0] calChannel_r;
   wire acqWindow_r, sampleTake_r, calDone_r, corrValid_r;
   wire [11:0] offsetCoeff_r, gainCoeff_r, corrResult_r;
   int failCount = 0, totalChecks = 0, n, t, i, takes;
   logic [31:0] r;
   logic [11:0] offs;
   logic [31:0] rows [0:4];

   adc_calibration_sequencer dut (.ref_clk, .rst, .ctrlWrEn, .ctrlWrData,
      .channelSelect, .divRatio, .acqSel, .rawSample, .convResult,
      .convValid, .ctrlRdData_r, .calChannel_r, .acqWindow_r, .sampleTake_r,
      .calDone_r, .offsetCoeff_r, .gainCoeff_r, .corrResult_r, .corrValid_r);

   ////////////////////////////////////////////////////////////////////////
   // Free running 200 MHz core clock.
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   function automatic int avgN(input logic [1:0] c);
      return c == 2'h0 ? `CAL_AVG_N0 : c == 2'h1 ? `CAL_AVG_N1 :
             c == 2'h2 ? `CAL_AVG_N2 : `CAL_AVG_N3;
   endfunction

   // Mean of a constant reading through the scaled reciprocal.
   function automatic logic [11:0] coef(input logic [11:0] x,
                                        input logic [1:0] c);
      logic [31:0] p;
      p = c == 2'h0 ? `CAL_RECIP_N0 : c == 2'h1 ? `CAL_RECIP_N1 :
          c == 2'h2 ? `CAL_RECIP_N2 : `CAL_RECIP_N3;
      p = x * avgN(c) * p;
      return p[27:16];
   endfunction

   task automatic check(input string name, input logic [31:0] seen, exp);
      totalChecks++;
      if (seen !== exp) begin
         failCount++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic results();
      if (failCount == 0 && totalChecks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // One-cycle write strobe; the value reads back after the taking edge.
   task automatic wr(input logic [7:0] d);
      @(posedge ref_clk);
      ctrlWrEn <= 1'b1;
      ctrlWrData <= d;
      @(posedge ref_clk);
      ctrlWrEn <= 1'b0;
      #1;
   endtask

   // Bounded wait for busy to drop; a hang ends the run as a failure.
   task automatic waitIdle();
      n = 0;
      takes = 0;
      while (ctrlRdData_r[7] === 1'b1 && n < 20000) begin
         @(posedge ref_clk);
         #1;
         n++;
         if (sampleTake_r === 1'b1)
            takes++;
      end
      if (n >= 20000) begin
         failCount++;
         results();
      end
   endtask

   task automatic conv(input logic [11:0] x, input logic [11:0] e);
      @(posedge ref_clk);
      convResult <= x;
      convValid <= 1'b1;
      @(posedge ref_clk);
      convValid <= 1'b0;
      #1;
      check("corrValid", corrValid_r, 1'b1);
      check("corrResult", corrResult_r, e);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      rst = 1'b1; ctrlWrEn = 1'b0; ctrlWrData = 8'h00; convValid = 1'b0;
      channelSelect = 4'h0; divRatio = 6'h01; acqSel = 2'h0;
      rawSample = 12'h000; convResult = 12'h000;
      // Rows: command, channel, acqSel, divRatio, constant reading.
      rows[0] = {8'h25, 4'hb, 2'h0, 6'h01, 12'h020};
      rows[1] = {8'h27, 4'hc, 2'h0, 6'h01, 12'hff0};
      rows[2] = {8'h05, 4'h0, 2'h3, 6'h02, 12'h030};
      rows[3] = {8'h17, 4'h1, 2'h1, 6'h00, 12'hfe0};
      rows[4] = {8'h35, 4'hb, 2'h0, 6'h01, 12'h020};
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      check("resetCtrl", ctrlRdData_r, 8'h00);
      check("resetGain", gainCoeff_r, 12'hfff);
      for (i = 0; i < 5; i++) begin
         r = rows[i];
         @(posedge ref_clk);
         channelSelect <= r[23:20];
         acqSel <= r[19:18];
         divRatio <= r[17:12];
         rawSample <= r[11:0];
         wr(r[31:24]);
         check("readback", ctrlRdData_r, {1'b1, r[30:24]});
         check("channel", calChannel_r, r[23:20]);
         waitIdle();
         t = 14 * avgN(r[29:28]) * (17 + r[19:18]) *
             (r[17:12] == 6'h00 ? 1 : r[17:12]);
         check("cycleLen", n >= t && n <= t + 3, 1'b1);
         check("takes", takes, 14 * avgN(r[29:28]));
         check("calDone", calDone_r, 1'b1);
         check("startClr", ctrlRdData_r, {1'b0, r[30:25], 1'b0});
         if (r[25])
            check("gainCoeff", gainCoeff_r, coef(r[11:0], r[29:28]));
         else
            check("offsetCoeff", offsetCoeff_r, coef(r[11:0], r[29:28]));
      end
      // Start without the mode bit is not stored and never runs; the other bits are stored.
      wr(8'h4b);
      check("noMode", ctrlRdData_r, 8'h4a);
      repeat (5) @(posedge ref_clk);
      #1;
      check("noModeBusy", ctrlRdData_r[7], 1'b0);
      // Writes while busy only reach the two disable bits.
      wr(8'h05);
      repeat (10) @(posedge ref_clk);
      wr(8'h4f);
      check("busyWrite", ctrlRdData_r, 8'hcd);
      waitIdle();
      check("busyEnd", ctrlRdData_r, 8'h4c);
      offs = coef(12'h020, 2'h0);
      check("offsetCoeff2", offsetCoeff_r, offs);
      // Correction with the gain term disabled, then both disabled.
      wr(8'h40);
      conv(12'h100, 12'h100 - offs);
      conv(12'h010, 12'h000);
      wr(8'h48);
      conv(12'h010, 12'h010);
      // Both terms on: the stored gain below full scale lifts the result.
      wr(8'h00);
      conv(12'h800, 12'h7f1);
      // Reset in mid-cycle clears the register and the offset coefficient and sets the gain coefficient to full scale.
      wr(8'h07);
      repeat (20) @(posedge ref_clk);
      rst <= 1'b1;
      @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      check("midReset", ctrlRdData_r, 8'h00);
      check("midResetGain", gainCoeff_r, 12'hfff);
      check("midResetOfs", offsetCoeff_r, 12'h000);
      results();
   end
endmodule // tb_top
